/* design/gpc_pkg.sv */
/*
 Package for the per-pin control block: register layout, field positions,
 reset values, function codes and settle time constants.
 Assumes a 125 MHz system clock.
*/
package gpc_pkg;
   localparam int NUM_PINS = 16;
   localparam int ALT_PINS = 8;
   localparam int CLK_MHZ = 125;
   // Register word addresses: one control word per pin, then a readback word
   localparam logic [7:0] ADDR_CTRL_BASE = 8'h00;
   localparam logic [7:0] ADDR_PIN_LEVEL = 8'h40;
   // Field positions in a control word
   localparam int POS_DIR = 31;
   localparam int POS_TIME_HI = 19;
   localparam int POS_TIME_LO = 16;
   localparam int POS_LVL = 15;
   localparam int POS_DRV = 14;
   localparam int POS_SETTLE = 13;
   localparam int POS_INV = 12;
   localparam int POS_FN_HI = 9;
   localparam int POS_FN_LO = 0;
   // Reset values
   localparam logic RST_DIR = 1'b1;
   localparam logic [3:0] RST_TIME = 4'h0;
   localparam logic RST_DRV = 1'b0;
   localparam logic RST_SETTLE = 1'b0;
   localparam logic RST_INV = 1'b0;
   localparam logic [9:0] RST_FN = 10'h001;
   // Function codes
   localparam logic [9:0] FN_ALT = 10'h000;
   localparam logic [9:0] FN_LOGIC = 10'h001;
   localparam logic [9:0] FN_DSP = 10'h002;
   localparam logic [9:0] FN_IRQ = 10'h003;
   localparam logic [9:0] FN_LOOP_CLK = 10'h010;
   localparam logic [9:0] FN_LOOP_LOCK = 10'h018;
   localparam logic [9:0] FN_DERIVED_CLK = 10'h048;
   localparam logic [9:0] FN_FIRST_PULSE_WIDTH_OUTPUT = 10'h080;
   localparam logic [9:0] FN_PWM2 = 10'h081;
   // Settle times in microseconds, code 0x0 to 0xa
   localparam int SETTLE_US [0:10] = '{100, 1500, 3000, 6000, 12000, 24000, 48000,
                                       96000, 192000, 384000, 768000};
   localparam int CNT_W = 27;
   localparam logic [3:0] TIME_MAX_CODE = 4'ha;
   // Per-pin control fields
   typedef struct packed {
      logic dir;
      logic [3:0] settle_time;
      logic level;
      logic drv_od;
      logic settle_en;
      logic invert;
      logic [9:0] func;
   } gpc_ctrl_t;
   // Sources a pin can be routed to
   typedef struct packed {
      logic irq;
      logic loop_clk;
      logic loop_lock;
      logic derived_clk;
      logic first_pulse_width_output;
      logic pwm2;
   } gpc_src_t;
endpackage

/* design/gpc_pin_control.sv */
/*
 Per-pin GPIO control for 16 pins with settle filter and function routing.
 Assumes synchronous pin inputs, a 125 MHz clock and a strobe register port.
*/
// Contract
// R1: Settle time codes 0x0-0xa give 100 us to 768 ms; 0xb-0xf reserved.
// R2: Settle enable bit turns input debouncing on; resets off.
// R3: With settling on, new input level accepted after stable for selected time.
// R4: Output level bit is write-only; reads do not show it.
// R5: With invert set, the pin drives the opposite of the level bit.
// R6: Driver type bit: 0 push-pull, 1 open-drain; resets push-pull.
// R7: Driver type ignored for codes 0x000 and 0x002; 0x002 always push-pull.
// R8: Invert bit inverts the selected output; ignored for 0x000 and 0x002.
// R9: Each pin has a ten-bit function select, resetting to plain logic I/O.
// R10: Direction must match the function; device applies function per direction.
// R11: Code 0x001 outputs the level bit, or is a logic input.
// R12: Code 0x002 connects the pin to the DSP; DSP sets direction.
// R13: Code 0x003 on pins 1-8 outputs the first interrupt request.
// R14: Code 0x010 on pins 1-8 outputs the frequency loop clock.
// R15: Code 0x018 on pins 1-8 outputs frequency loop lock status.
// R16: Code 0x048 on pins 1-8 outputs the derived clock.
// R17: Code 0x080 on all pins outputs first PWM; 0x081 second PWM.
// R18: Controls are replicated for each of 16 pins by pin number.
// R19: After reset the level bit follows the pin's sensed level.
// R20: Direction bit 0 output, 1 input; resets input; ignored for 0x000/0x002.
`timescale 1ns/1ps
module gpc_pin_control (
   input wire logic clock, // System clock, 125 MHz
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic clk_en, // Freezes all state while low
   input wire logic [7:0] reg_addr, // Word address
   input wire logic [31:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [31:0] reg_rdata, // Read data, cycle after strobe
   input wire logic [15:0] pin_in, // Sensed pin levels
   output logic [15:0] pin_out, // Pin output values
   output logic [15:0] pin_oe_n, // Pin output enables, low drives
   input wire logic [15:0] alt_out, // Pin-specific alternate outputs
   input wire logic [15:0] alt_oe_n, // Pin-specific alternate enables, low drives
   input wire logic [15:0] alt_od, // Alternate function wants open-drain
   input wire logic [15:0] dsp_out, // DSP low-latency outputs
   input wire logic [15:0] dsp_dir, // DSP direction, 1 input
   input wire gpc_pkg::gpc_src_t src, // Internal output sources
   output logic [15:0] pin_level, // Filtered pin levels to the core
   output logic [15:0] dsp_in // Filtered pin levels to the DSP
);
   gpc_pkg::gpc_ctrl_t ctrl [gpc_pkg::NUM_PINS];
   logic [15:0] filt;
   logic [gpc_pkg::CNT_W-1:0] cnt [gpc_pkg::NUM_PINS];
   logic init_done;
   logic [15:0] next_out;
   logic [15:0] next_oe_n;

   // Settle time in clock cycles for a code, reserved codes use the longest
   function automatic logic [gpc_pkg::CNT_W-1:0] settle_cycles(input logic [3:0] code);
      int idx;
      idx = (code > gpc_pkg::TIME_MAX_CODE) ? 10 : int'(code);
      return gpc_pkg::CNT_W'(gpc_pkg::SETTLE_US[idx] * gpc_pkg::CLK_MHZ); // [R1]
   endfunction

   // Whether a read or write address selects pin p's control word
   function automatic logic hit_ctrl(input logic [7:0] a, input int p);
      return a == gpc_pkg::ADDR_CTRL_BASE + 8'(p);
   endfunction

   // Control word registers, one per pin
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int p = 0; p < gpc_pkg::NUM_PINS; p++) begin
            ctrl[p].dir <= gpc_pkg::RST_DIR; // [R20]
            ctrl[p].settle_time <= gpc_pkg::RST_TIME;
            ctrl[p].level <= 1'b0;
            ctrl[p].drv_od <= gpc_pkg::RST_DRV; // [R6]
            ctrl[p].settle_en <= gpc_pkg::RST_SETTLE; // [R2]
            ctrl[p].invert <= gpc_pkg::RST_INV;
            ctrl[p].func <= gpc_pkg::RST_FN; // [R9]
         end
      end else if (clk_en) begin
         for (int p = 0; p < gpc_pkg::NUM_PINS; p++) begin
            if (!init_done) begin
               ctrl[p].level <= pin_in[p]; // [R19]
            end
            if (reg_wr && hit_ctrl(reg_addr, p)) begin // [R18]
               ctrl[p].dir <= reg_wdata[gpc_pkg::POS_DIR];
               ctrl[p].settle_time <= reg_wdata[gpc_pkg::POS_TIME_HI:gpc_pkg::POS_TIME_LO];
               ctrl[p].level <= reg_wdata[gpc_pkg::POS_LVL];
               ctrl[p].drv_od <= reg_wdata[gpc_pkg::POS_DRV];
               ctrl[p].settle_en <= reg_wdata[gpc_pkg::POS_SETTLE];
               ctrl[p].invert <= reg_wdata[gpc_pkg::POS_INV];
               ctrl[p].func <= reg_wdata[gpc_pkg::POS_FN_HI:gpc_pkg::POS_FN_LO];
            end
         end
      end
   end

   // Marks the first enabled cycle after reset release
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         init_done <= 1'b0;
      end else if (clk_en) begin
         init_done <= 1'b1;
      end
   end

   // Input settle filter per pin
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         filt <= '0;
         for (int p = 0; p < gpc_pkg::NUM_PINS; p++) begin
            cnt[p] <= '0;
         end
      end else if (clk_en) begin
         for (int p = 0; p < gpc_pkg::NUM_PINS; p++) begin
            if (!init_done || !ctrl[p].settle_en) begin
               filt[p] <= pin_in[p]; // [R2]
               cnt[p] <= '0;
            end else if (pin_in[p] == filt[p]) begin
               cnt[p] <= '0;
            end else if (cnt[p] + 1'b1 >= settle_cycles(ctrl[p].settle_time)) begin
               filt[p] <= pin_in[p]; // [R3]
               cnt[p] <= '0;
            end else begin
               cnt[p] <= cnt[p] + 1'b1;
            end
         end
      end
   end

   // Routes each pin's selected function to its driver
   always_comb begin
      next_out = '0;
      next_oe_n = '1;
      for (int p = 0; p < gpc_pkg::NUM_PINS; p++) begin
         logic v;
         logic lo;
         v = 1'b0;
         lo = (p < gpc_pkg::ALT_PINS);
         unique case (ctrl[p].func)
            gpc_pkg::FN_LOGIC: v = ctrl[p].level; // [R11]
            gpc_pkg::FN_IRQ: v = lo & src.irq; // [R13]
            gpc_pkg::FN_LOOP_CLK: v = lo & src.loop_clk; // [R14]
            gpc_pkg::FN_LOOP_LOCK: v = lo & src.loop_lock; // [R15]
            gpc_pkg::FN_DERIVED_CLK: v = lo & src.derived_clk; // [R16]
            gpc_pkg::FN_FIRST_PULSE_WIDTH_OUTPUT: v = src.first_pulse_width_output; // [R17]
            gpc_pkg::FN_PWM2: v = src.pwm2; // [R17]
            default: v = 1'b0;
         endcase
         v = v ^ ctrl[p].invert; // [R5] [R8]
         if (ctrl[p].func == gpc_pkg::FN_ALT) begin
            // Alternate function owns direction and driver type
            next_out[p] = alt_out[p]; // [R7]
            next_oe_n[p] = alt_oe_n[p] | (alt_od[p] & alt_out[p]);
         end else if (ctrl[p].func == gpc_pkg::FN_DSP) begin
            next_out[p] = dsp_out[p]; // [R12]
            next_oe_n[p] = dsp_dir[p]; // [R7]
         end else if (!ctrl[p].dir) begin
            // Open drain releases the pin for a high level
            next_out[p] = v; // [R10] [R20]
            next_oe_n[p] = ctrl[p].drv_od & v; // [R6]
         end
      end
   end

   // Registered pin drivers and core-side levels
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_out <= '0;
         pin_oe_n <= '1;
         pin_level <= '0;
         dsp_in <= '0;
      end else if (clk_en) begin
         pin_out <= next_out;
         pin_oe_n <= next_oe_n;
         pin_level <= filt;
         dsp_in <= filt;
      end
   end

   // Register reads: control words hide the level bit, readback word shows pins
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else if (clk_en) begin
         reg_rdata <= '0;
         if (reg_rd) begin
            if (reg_addr == gpc_pkg::ADDR_PIN_LEVEL) begin
               reg_rdata <= {16'h0000, filt};
            end
            for (int p = 0; p < gpc_pkg::NUM_PINS; p++) begin
               if (hit_ctrl(reg_addr, p)) begin
                  reg_rdata <= {ctrl[p].dir, 11'h000, ctrl[p].settle_time, 1'b0, // [R4]
                                ctrl[p].drv_od, ctrl[p].settle_en, ctrl[p].invert, 2'h0, ctrl[p].func};
               end
            end
         end
      end
   end

   // Checks
   AST_LVL_HIDDEN: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
      (clk_en && reg_rd && reg_addr < 8'h10) |=> !reg_rdata[gpc_pkg::POS_LVL])
      else $error("Level bit visible on read");
   AST_RST_FN: assert property (@(posedge clock) disable iff (!rst_n) // [R9]
      $rose(init_done) |-> ctrl[0].func == gpc_pkg::FN_LOGIC && ctrl[0].dir)
      else $error("Bad reset function");
   AST_LOGIC_OUT: assert property (@(posedge clock) disable iff (!rst_n) // [R11]
      (clk_en && ctrl[0].func == gpc_pkg::FN_LOGIC && !ctrl[0].dir)
      |=> pin_out[0] == ($past(ctrl[0].level) ^ $past(ctrl[0].invert))
          && pin_oe_n[0] == ($past(ctrl[0].drv_od) & pin_out[0]))
      else $error("Logic output wrong");
   AST_INPUT_HIZ: assert property (@(posedge clock) disable iff (!rst_n) // [R20]
      (clk_en && ctrl[1].dir && ctrl[1].func == gpc_pkg::FN_LOGIC) |=> pin_oe_n[1])
      else $error("Input pin driven");
   AST_DSP_CMOS: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
      (clk_en && ctrl[0].func == gpc_pkg::FN_DSP && !dsp_dir[0]) |=> !pin_oe_n[0])
      else $error("DSP output not push-pull");
   AST_OD_RELEASE: assert property (@(posedge clock) disable iff (!rst_n) // [R6]
      (clk_en && ctrl[0].func == gpc_pkg::FN_LOGIC && !ctrl[0].dir && ctrl[0].drv_od && next_out[0])
      |=> pin_oe_n[0])
      else $error("Open drain drove high");
   AST_HI_PIN_IRQ: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
      (clk_en && ctrl[8].func == gpc_pkg::FN_IRQ && !ctrl[8].invert) |=> !pin_out[8])
      else $error("Interrupt routed to high pin");
   AST_NO_SETTLE: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
      (clk_en && init_done && !ctrl[4].settle_en) |=> filt[4] == $past(pin_in[4]))
      else $error("Unfiltered input lagged");
   AST_SETTLE_HOLD: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
      (clk_en && ctrl[1].settle_en && init_done && cnt[1] == '0 && pin_in[1] != filt[1]) |=> filt[1] == $past(filt[1]))
      else $error("Input accepted too early");

   // Reset capture, per-pin writes and read path
   AST_LVL_INIT: assert property (@(posedge clock) disable iff (!rst_n) // [R19]
      $rose(init_done) |-> ctrl[0].level == $past(pin_in[0]))
      else $error("Level bit did not follow the pin after reset");
   AST_WR_ONE_PIN: assert property (@(posedge clock) disable iff (!rst_n) // [R18]
      (clk_en && init_done && reg_wr && reg_addr == 8'h01)
      |=> $stable(ctrl[0]) && ctrl[1].func == $past(reg_wdata[gpc_pkg::POS_FN_HI:gpc_pkg::POS_FN_LO]))
      else $error("Write reached the wrong pin");
   AST_RD_IDLE: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
      (clk_en && !reg_rd) |=> reg_rdata == '0)
      else $error("Read data held past its cycle");
   AST_RD_LEVEL: assert property (@(posedge clock) disable iff (!rst_n) // [R11]
      (clk_en && reg_rd && reg_addr == gpc_pkg::ADDR_PIN_LEVEL) |=> reg_rdata == {16'h0000, $past(filt)})
      else $error("Level word wrong");

   // Output routing and polarity
   AST_INV_LOGIC: assert property (@(posedge clock) disable iff (!rst_n) // [R5]
      (clk_en && ctrl[0].func == gpc_pkg::FN_LOGIC && !ctrl[0].dir && ctrl[0].invert)
      |=> pin_out[0] != $past(ctrl[0].level))
      else $error("Inverted level not driven");
   AST_IRQ_LOW_PIN: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
      (clk_en && ctrl[0].func == gpc_pkg::FN_IRQ && !ctrl[0].dir && !ctrl[0].invert)
      |=> pin_out[0] == $past(src.irq) && !pin_oe_n[0])
      else $error("Interrupt not routed");
   AST_LOOP_CLK: assert property (@(posedge clock) disable iff (!rst_n) // [R14]
      (clk_en && ctrl[0].func == gpc_pkg::FN_LOOP_CLK && !ctrl[0].dir && !ctrl[0].invert)
      |=> pin_out[0] == $past(src.loop_clk))
      else $error("Loop clock not routed");
   AST_LOOP_LOCK: assert property (@(posedge clock) disable iff (!rst_n) // [R15]
      (clk_en && ctrl[0].func == gpc_pkg::FN_LOOP_LOCK && !ctrl[0].dir && !ctrl[0].invert)
      |=> pin_out[0] == $past(src.loop_lock))
      else $error("Lock status not routed");
   AST_DERIVED_CLK: assert property (@(posedge clock) disable iff (!rst_n) // [R16]
      (clk_en && ctrl[0].func == gpc_pkg::FN_DERIVED_CLK && !ctrl[0].dir && !ctrl[0].invert)
      |=> pin_out[0] == $past(src.derived_clk))
      else $error("Derived clock not routed");
   AST_PWM_INV: assert property (@(posedge clock) disable iff (!rst_n) // [R8]
      (clk_en && ctrl[0].func == gpc_pkg::FN_FIRST_PULSE_WIDTH_OUTPUT && !ctrl[0].dir)
      |=> pin_out[0] == ($past(src.first_pulse_width_output) ^ $past(ctrl[0].invert)))
      else $error("PWM polarity wrong");
   AST_PWM2_HI_PIN: assert property (@(posedge clock) disable iff (!rst_n) // [R17]
      (clk_en && ctrl[8].func == gpc_pkg::FN_PWM2 && !ctrl[8].dir && !ctrl[8].invert)
      |=> pin_out[8] == $past(src.pwm2))
      else $error("Second PWM not routed");
   AST_DSP_FOLLOW: assert property (@(posedge clock) disable iff (!rst_n) // [R12]
      (clk_en && ctrl[0].func == gpc_pkg::FN_DSP)
      |=> pin_out[0] == $past(dsp_out[0]) && pin_oe_n[0] == $past(dsp_dir[0]))
      else $error("DSP route wrong");
   AST_ALT_FOLLOW: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
      (clk_en && ctrl[0].func == gpc_pkg::FN_ALT) |=> pin_out[0] == $past(alt_out[0]))
      else $error("Alternate value not routed");
   AST_ALT_OD: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
      (clk_en && ctrl[0].func == gpc_pkg::FN_ALT && alt_od[0] && alt_out[0])
      |=> pin_oe_n[0])
      else $error("Alternate open drain drove high");

   // Input settle filter
   AST_SETTLE_LIMIT: assert property (@(posedge clock) disable iff (!rst_n) // [R1]
      (ctrl[1].settle_en && ctrl[1].settle_time == 4'h0)
      |-> cnt[1] < gpc_pkg::CNT_W'(gpc_pkg::SETTLE_US[0] * gpc_pkg::CLK_MHZ))
      else $error("Settle count past shortest time");
   AST_SETTLE_RESTART: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
      (clk_en && init_done && ctrl[1].settle_en && pin_in[1] == filt[1])
      |=> cnt[1] == '0)
      else $error("Settle count not restarted");
   AST_NO_SETTLE_CNT: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
      (clk_en && !ctrl[4].settle_en) |=> cnt[4] == '0)
      else $error("Settle count ran while disabled");

   // Clock enable low holds controls and pins
   AST_FREEZE: assert property (@(posedge clock) disable iff (!rst_n) // [R18]
      !clk_en
      |=> $stable(pin_out) && $stable(pin_oe_n) && $stable(ctrl[0]))
      else $error("State moved while frozen");
endmodule

/* dv/gpc_pin_partner.sv */
/*
 External circuitry at the 16 pins: a per-pin driver and a pull-up.
 Assumes the bench sets ext_en and ext_val off the clock edge.
*/
`timescale 1ns/1ps
module gpc_pin_partner (
   input wire logic [15:0] pin_out, // Value the block drives
   input wire logic [15:0] pin_oe_n, // Low where the block drives
   input wire logic [15:0] ext_en, // Outside driver active
   input wire logic [15:0] ext_val, // Outside driver level
   output logic [15:0] pin_in // Resolved wire level
);
   // A released pin with no outside driver floats up to the pull-up level
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
      end
   end
endmodule

/* dv/gpio_pin_control_bench.sv */
/*
 Self-checking bench for the per-pin control block.
 Assumes the strobe register port and a 125 MHz clock; clk_en held high except during the freeze check.
*/
`timescale 1ns/1ps
module gpio_pin_control_bench;
   logic clock, rst_n, reg_wr, reg_rd, clk_en;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [15:0] pin_in, pin_out, pin_oe_n, alt_out, alt_oe_n, alt_od, dsp_out, dsp_dir;
   logic [15:0] pin_level, dsp_in, ext_en, ext_val;
   gpc_pkg::gpc_src_t src;
   int fail_count = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [9:0] fcodes [6] = '{gpc_pkg::FN_IRQ, gpc_pkg::FN_LOOP_CLK, gpc_pkg::FN_LOOP_LOCK,
                              gpc_pkg::FN_DERIVED_CLK, gpc_pkg::FN_FIRST_PULSE_WIDTH_OUTPUT, gpc_pkg::FN_PWM2};

   gpc_pin_control dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .alt_out(alt_out),
      .alt_oe_n(alt_oe_n), .alt_od(alt_od), .dsp_out(dsp_out), .dsp_dir(dsp_dir), .src(src),
      .pin_level(pin_level), .dsp_in(dsp_in));
   gpc_pin_partner far (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(ext_en),
      .ext_val(ext_val), .pin_in(pin_in));

   // Clock source
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // Closing report
   task automatic conclude();
      if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Hang guard
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         fail_count++;
         conclude();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Let n edges pass, then sample settled outputs
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // Main sequence
   initial begin
      logic [31:0] v;
      rst_n = 1'b0;
      clk_en = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      alt_out = 16'h0;
      alt_oe_n = 16'hffff;
      alt_od = 16'h0;
      dsp_out = 16'h0;
      dsp_dir = 16'hffff;
      src = '0;
      ext_en = 16'hffff;
      ext_val = 16'h0;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      // Reset contents of every control word, level bit reads zero
      for (int i = 0; i < 16; i++) begin
         rd(8'(i), v);
         chk("ctrl reset", 32'h80000001, v);
      end
      rd(8'h20, v);
      chk("unmapped read", 32'h0, v);
      // Logic output, level readback hidden, inversion, open drain
      wr(8'h00, 32'h00008001);
      tick(2);
      chk("out level", 32'h0, {30'h0, pin_out[0], pin_oe_n[0]} ^ 32'h2);
      rd(8'h00, v);
      chk("level hidden", 32'h00000001, v);
      wr(8'h00, 32'h00009001);
      tick(2);
      chk("inverted", 32'h0, {31'h0, pin_out[0]});
      wr(8'h00, 32'h00004001);
      tick(2);
      chk("od low drives", 32'h0, {31'h0, pin_oe_n[0]});
      wr(8'h00, 32'h0000c001);
      tick(2);
      chk("od high released", 32'h1, {31'h0, pin_oe_n[0]});
      // Internal sources on pin 1 and pin 9
      for (int k = 0; k < 6; k++) begin
         wr(8'h00, {22'h0, fcodes[k]});
         wr(8'h08, {22'h0, fcodes[k]});
         src <= gpc_pkg::gpc_src_t'(6'h20 >> k);
         tick(2);
         chk("src pin1", 32'h1, {31'h0, pin_out[0]});
         chk("src pin9", {31'h0, k >= 4}, {31'h0, pin_out[8]});
         src <= '0;
         tick(2);
         chk("src idle", 32'h0, {30'h0, pin_out[0], pin_oe_n[0]});
      end
      // DSP route ignores invert and open drain
      wr(8'h00, 32'h00005000 | {22'h0, gpc_pkg::FN_DSP});
      dsp_out[0] <= 1'b1;
      dsp_dir[0] <= 1'b0;
      tick(2);
      chk("dsp high", 32'h2, {30'h0, pin_out[0], pin_oe_n[0]});
      dsp_out[0] <= 1'b0;
      tick(2);
      chk("dsp cmos low", 32'h0, {30'h0, pin_out[0], pin_oe_n[0]});
      dsp_dir[0] <= 1'b1;
      tick(2);
      chk("dsp input", 32'h1, {31'h0, pin_oe_n[0]});
      // Alternate route ignores invert and open drain
      wr(8'h00, 32'h00005000 | {22'h0, gpc_pkg::FN_ALT});
      alt_out[0] <= 1'b1;
      alt_oe_n[0] <= 1'b0;
      tick(2);
      chk("alt", 32'h2, {30'h0, pin_out[0], pin_oe_n[0]});
      alt_od[0] <= 1'b1;
      tick(2);
      chk("alt od released", 32'h3, {30'h0, pin_out[0], pin_oe_n[0]});
      // Clock enable low freezes the pins and ignores writes
      clk_en <= 1'b0;
      alt_out[0] <= 1'b0;
      wr(8'h00, 32'h80000001);
      tick(2);
      chk("frozen pin", 32'h3, {30'h0, pin_out[0], pin_oe_n[0]});
      clk_en <= 1'b1;
      rd(8'h00, v);
      chk("frozen write ignored", 32'h00005000, v);
      // Unfiltered input on pin 3
      ext_val[2] <= 1'b1;
      tick(3);
      chk("raw level", 32'h1, {31'h0, pin_level[2]});
      rd(8'h40, v);
      chk("level word", 32'h1, {31'h0, v[2]});
      // Settle filter on pin 2 at code 0: 12500 cycles
      wr(8'h01, 32'h80002001);
      tick(4);
      ext_val[1] <= 1'b1;
      tick(6000);
      ext_val[1] <= 1'b0;
      tick(100);
      ext_val[1] <= 1'b1;
      tick(12300);
      chk("settle early", 32'h0, {31'h0, pin_level[1]});
      tick(400);
      chk("settle done", 32'h1, {31'h0, pin_level[1]});
      chk("settle to dsp", 32'h1, {31'h0, dsp_in[1]});
      conclude();
   end
endmodule
